// [touch_adc_control.sv]
`timescale 1ns/1ps
// Summary of operation
// - open-drain alert idles released high whenever no enabled touch is reported.
// - with reporting enabled, a touch pulls the alert low.
// - reporting is enabled after power-up, before any word.
// - detecting a start flag disables touch reporting immediately.
// - an asserted alert releases at the fourth falling edge after start.
// - that release does not re-enable reporting; new power bits decide.
// - re-enabled reporting resumes only when the current conversion completes or chip select rises.
// - a start flag arriving before conversion end keeps reporting disabled.
// - reporting may stay enabled in power-down; host converts after touch.
// - first coordinate conversion after power-up is valid with settled reference.
// - serial input bits are ignored until a start flag is seen.
// - three channel bits choose multiplexer, panel drivers and reference inputs.
// - resolution bit zero gives 12-bit, one gives 8-bit conversion.
// - reference-mode bit one is single-ended, zero is differential.
// - differential takes reference from panel drivers, single-ended from reference pin.
// - reference and converter power are controlled independently by two bits.
// - power-up converter power bit is zero, reference power bit is one.
// - start bit 7, channel 6..4, resolution 3, reference mode 2, power 1..0.
// - new word may start every 15th cycle (12-bit) or 11th (8-bit).
// - between conversions, reporting disabled only when both power bits are one.
module touch_adc_control #(
    parameter int CONV_END_12BIT = touch_ctl_pkg::CONV_END_12,
    parameter int CONV_END_8BIT  = touch_ctl_pkg::CONV_END_8
) (
    // system clock and reset
    input  wire logic                    CLOCK,
    input  wire logic                    RESET_N,
    // serial control port
    input  wire logic                    SHIFT_CLOCK,
    input  wire logic                    CHIP_SEL_N,
    input  wire logic                    SERIAL_IN,
    // panel touch sense
    input  wire logic                    TOUCH_SENSE,
    // open-drain touch alert
    output logic                         TOUCH_ALERT_N_O,
    output logic                         TOUCH_ALERT_N_OE,
    // decoded conversion setup
    output touch_ctl_pkg::ctl_word_t     CTL_WORD,
    output logic                         REF_FROM_PANEL,
    output logic                         REF_POWERED,
    output logic                         ADC_POWERED,
    output logic                         CONVERTING,
    output logic                         TOUCH_REPORT_EN
);

    initial begin
        if (CONV_END_8BIT <= 8 || CONV_END_12BIT <= CONV_END_8BIT ||
            CONV_END_12BIT >= 31) begin
            $error("conversion end counts out of range");
        end
    end

    localparam logic [4:0] END_12 = 5'(CONV_END_12BIT);
    localparam logic [4:0] END_8  = 5'(CONV_END_8BIT);

    function automatic logic [4:0] conv_end(input touch_ctl_pkg::ctl_word_t w);
        conv_end = w.res_8bit ? END_8 : END_12;
    endfunction

    function automatic logic reporting_allowed(input touch_ctl_pkg::ctl_word_t w);
        reporting_allowed = {w.ref_power_ctl, w.adc_power_ctl}
                            != touch_ctl_pkg::PWR_ALWAYS_ON;
    endfunction

    // ---------------- link domain (shift clock) ----------------
    touch_ctl_pkg::frame_state_t state_r;
    logic [4:0]                  cnt_r;
    logic [6:0]                  shift_r;
    touch_ctl_pkg::ctl_word_t    word_r;
    logic                        start_tgl_r;
    logic                        word_tgl_r;
    logic                        rel_tgl_r;
    logic                        done_tgl_r;
    logic                        link_arst_n;
    logic                        start_seen;
    logic                        word_done;

    // chip select high holds the framing in reset, so no clock is needed to abort
    assign link_arst_n = RESET_N & ~CHIP_SEL_N;

    assign start_seen = (state_r != touch_ctl_pkg::RECEIVE) && SERIAL_IN;
    assign word_done  = (state_r == touch_ctl_pkg::RECEIVE)
                        && (cnt_r == touch_ctl_pkg::CNT_LAST_BIT);

    always_ff @(posedge SHIFT_CLOCK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            state_r <= touch_ctl_pkg::HUNT;
            cnt_r   <= '0;
            shift_r <= '0;
        end else begin
            unique case (state_r)
                touch_ctl_pkg::HUNT: begin
                    if (SERIAL_IN) begin
                        state_r <= touch_ctl_pkg::RECEIVE;
                        cnt_r   <= touch_ctl_pkg::CNT_START;
                        shift_r <= 7'h01;
                    end
                end
                touch_ctl_pkg::RECEIVE: begin
                    shift_r <= {shift_r[5:0], SERIAL_IN};
                    cnt_r   <= cnt_r + 5'h01;
                    if (cnt_r == touch_ctl_pkg::CNT_LAST_BIT) begin
                        state_r <= touch_ctl_pkg::CONVERT;
                    end
                end
                touch_ctl_pkg::CONVERT: begin
                    // overlapped writes: a new start may arrive mid-conversion
                    if (SERIAL_IN) begin
                        state_r <= touch_ctl_pkg::RECEIVE;
                        cnt_r   <= touch_ctl_pkg::CNT_START;
                        shift_r <= 7'h01;
                    end else if (cnt_r != touch_ctl_pkg::CNT_MAX) begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
            endcase
        end
    end

    // toggles and the loaded word survive chip select so crossings stay coherent
    always_ff @(posedge SHIFT_CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            start_tgl_r <= 1'b0;
        end else if (start_seen && !CHIP_SEL_N) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    always_ff @(posedge SHIFT_CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            word_tgl_r <= 1'b0;
            word_r     <= touch_ctl_pkg::CTL_RESET;
        end else if (word_done && !CHIP_SEL_N) begin
            // word_r only moves with its toggle, so the far side reads a settled word
            word_r     <= {shift_r, SERIAL_IN};
            word_tgl_r <= ~word_tgl_r;
        end
    end

    // release counts falls, so it lands at the fourth fall whether or not a touch is held
    always_ff @(negedge SHIFT_CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rel_tgl_r <= 1'b0;
        end else if (state_r != touch_ctl_pkg::HUNT && cnt_r == touch_ctl_pkg::CNT_RELEASE) begin
            rel_tgl_r <= ~rel_tgl_r;
        end
    end

    always_ff @(negedge SHIFT_CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_tgl_r <= 1'b0;
        end else if (state_r == touch_ctl_pkg::CONVERT && cnt_r == conv_end(word_r)) begin
            done_tgl_r <= ~done_tgl_r;
        end
    end

    // ---------------- system domain ----------------
    logic [3:0] tgl_s1_r;
    logic [3:0] tgl_s2_r;
    logic [3:0] tgl_s3_r;
    logic [3:0] evt;
    logic       cs_s1_r;
    logic       cs_s2_r;
    logic       touch_s1_r;
    logic       touch_s2_r;
    logic       cs_d_r;
    logic       start_evt;
    logic       rel_evt;
    logic       word_evt;
    logic       done_evt;
    logic       abort_evt;
    logic       touch_s;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tgl_s1_r <= '0;
            tgl_s2_r <= '0;
            tgl_s3_r <= '0;
        end else begin
            tgl_s1_r <= {done_tgl_r, word_tgl_r, rel_tgl_r, start_tgl_r};
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign evt       = tgl_s2_r ^ tgl_s3_r;
    assign start_evt = evt[0];
    assign rel_evt   = evt[1];
    assign word_evt  = evt[2];
    assign done_evt  = evt[3];

    // chip select idles high, so its synchroniser resets high
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r  <= 1'b1;
        end else begin
            cs_s1_r <= CHIP_SEL_N;
            cs_s2_r <= cs_s1_r;
            cs_d_r  <= cs_s2_r;
        end
    end

    // touch idles released, so a reset cannot fake a touch
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            touch_s1_r <= 1'b0;
            touch_s2_r <= 1'b0;
        end else begin
            touch_s1_r <= TOUCH_SENSE;
            touch_s2_r <= touch_s1_r;
        end
    end

    assign touch_s   = touch_s2_r;
    assign abort_evt = cs_s2_r && !cs_d_r;

    touch_ctl_pkg::ctl_word_t ctl_r;
    logic                     pending_en_r;
    logic                     report_en_r;
    logic                     converting_r;
    logic                     alert_low_r;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_r <= touch_ctl_pkg::CTL_RESET;
        end else if (word_evt) begin
            // word_r has been stable for at least two system cycles by now
            ctl_r <= word_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pending_en_r <= 1'b1;
        end else if (word_evt) begin
            // held back until the conversion ends, so no alert fires mid-conversion
            pending_en_r <= reporting_allowed(word_r);
        end
    end

    // chip select rising always follows the start it aborts, so the abort wins
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            converting_r <= 1'b0;
        end else if (abort_evt) begin
            converting_r <= 1'b0;
        end else if (start_evt) begin
            converting_r <= 1'b1;
        end else if (done_evt) begin
            converting_r <= 1'b0;
        end
    end

    // a start beats a simultaneous conversion end, an abort beats both
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            report_en_r <= 1'b1;
        end else if (abort_evt) begin
            report_en_r <= pending_en_r;
        end else if (start_evt) begin
            report_en_r <= 1'b0;
        end else if (done_evt) begin
            report_en_r <= pending_en_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            alert_low_r <= 1'b0;
        end else if (report_en_r && !start_evt) begin
            alert_low_r <= touch_s;
        end else if (rel_evt || abort_evt) begin
            // a word aborted before its fourth fall never sees it, so release here too
            alert_low_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TOUCH_ALERT_N_O  <= 1'b1;
            TOUCH_ALERT_N_OE <= 1'b0;
        end else begin
            // drive low only while asserting, otherwise released to the pull-up
            TOUCH_ALERT_N_O  <= ~alert_low_r;
            TOUCH_ALERT_N_OE <= alert_low_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            CTL_WORD <= touch_ctl_pkg::CTL_RESET;
        end else begin
            CTL_WORD <= ctl_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            REF_FROM_PANEL <= 1'b1;
        end else begin
            REF_FROM_PANEL <= ~ctl_r.ref_mode_sel;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            REF_POWERED <= 1'b1;
        end else begin
            REF_POWERED <= ctl_r.ref_power_ctl;
        end
    end

    // converter wakes instantly for each conversion, so the first is valid
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ADC_POWERED <= 1'b0;
        end else begin
            ADC_POWERED <= ctl_r.adc_power_ctl | converting_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            CONVERTING <= 1'b0;
        end else begin
            CONVERTING <= converting_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TOUCH_REPORT_EN <= 1'b1;
        end else begin
            TOUCH_REPORT_EN <= report_en_r;
        end
    end

endmodule

// [touch_adc_control_asserts.sv]
`timescale 1ns/1ps
module touch_adc_control_asserts (
    // design ports watched
    input wire logic                     CLOCK,
    input wire logic                     RESET_N,
    input wire logic                     TOUCH_SENSE,
    input wire logic                     TOUCH_ALERT_N_O,
    input wire logic                     TOUCH_ALERT_N_OE,
    input wire touch_ctl_pkg::ctl_word_t CTL_WORD,
    input wire logic                     REF_FROM_PANEL,
    input wire logic                     CONVERTING,
    input wire logic                     TOUCH_REPORT_EN
);
    wire logic [1:0] pwr = {CTL_WORD.ref_power_ctl, CTL_WORD.adc_power_ctl};
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    AST_IDLE_HIGH: assert property (!TOUCH_ALERT_N_OE |-> TOUCH_ALERT_N_O)
        else $error("alert not idle high");
    AST_TOUCH_PULLS: assert property ((TOUCH_SENSE && TOUCH_REPORT_EN)[*5] |-> TOUCH_ALERT_N_OE)
        else $error("touch not reported");
    AST_RESET_VALUES: assert property ($rose(RESET_N) |-> TOUCH_REPORT_EN
        && CTL_WORD == touch_ctl_pkg::CTL_RESET) else $error("bad power-up state");
    AST_START_SILENCES: assert property ($rose(CONVERTING) |-> !TOUCH_REPORT_EN)
        else $error("reporting on after start");
    AST_EN_AT_END: assert property ($rose(TOUCH_REPORT_EN) |-> $fell(CONVERTING))
        else $error("reporting on before end");
    AST_ON_SILENT: assert property ($fell(CONVERTING) && pwr == 2'h3 |-> !TOUCH_REPORT_EN)
        else $error("reporting on with both bits");
    AST_OFF_REPORTS: assert property ($fell(CONVERTING) && pwr != 2'h3 |-> TOUCH_REPORT_EN)
        else $error("reporting off after end");
    AST_REF_SOURCE: assert property (REF_FROM_PANEL == !CTL_WORD.ref_mode_sel)
        else $error("reference source wrong");
    AST_ALERT_HELD: assert property ($fell(TOUCH_REPORT_EN) && TOUCH_ALERT_N_OE
        |-> TOUCH_ALERT_N_OE [*3]) else $error("alert released early");
    cover property ($rose(TOUCH_ALERT_N_OE));
    cover property ($fell(CONVERTING) && TOUCH_REPORT_EN);
    cover property ($fell(TOUCH_REPORT_EN) && TOUCH_ALERT_N_OE);
endmodule
bind touch_adc_control touch_adc_control_asserts i_touch_adc_control_asserts (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .TOUCH_SENSE(TOUCH_SENSE),
    .TOUCH_ALERT_N_O(TOUCH_ALERT_N_O), .TOUCH_ALERT_N_OE(TOUCH_ALERT_N_OE),
    .CTL_WORD(CTL_WORD), .REF_FROM_PANEL(REF_FROM_PANEL), .CONVERTING(CONVERTING),
    .TOUCH_REPORT_EN(TOUCH_REPORT_EN));

// [touch_adc_control_tb_top.sv]
`timescale 1ns/1ps
module touch_adc_control_tb_top;
    localparam int            CE12 = 16;
    localparam int            CE8  = 12;
    logic                     clock, reset_n, touch_sense, shift_clock, chip_sel_n, serial_in;
    logic                     alert_o, alert_oe, ref_panel, ref_pwr, adc_pwr, converting, report_en;
    touch_ctl_pkg::ctl_word_t ctl_word;
    wire logic                alert_wire = alert_oe ? 1'b0 : 1'b1;
    int                       mismatches, cmp_count;
    logic [7:0]               tbl [4] = '{8'h89, 8'hC4, 8'hAB, 8'hF2};
    always #2.5 clock = ~clock;
    touch_adc_control #(.CONV_END_12BIT(CE12), .CONV_END_8BIT(CE8)) i_touch_adc_control (
        .CLOCK(clock), .RESET_N(reset_n), .SHIFT_CLOCK(shift_clock),
        .CHIP_SEL_N(chip_sel_n), .SERIAL_IN(serial_in), .TOUCH_SENSE(touch_sense),
        .TOUCH_ALERT_N_O(alert_o), .TOUCH_ALERT_N_OE(alert_oe), .CTL_WORD(ctl_word),
        .REF_FROM_PANEL(ref_panel), .REF_POWERED(ref_pwr), .ADC_POWERED(adc_pwr),
        .CONVERTING(converting), .TOUCH_REPORT_EN(report_en));
    touch_host_model i_touch_host_model (
        .SHIFT_CLOCK(shift_clock), .CHIP_SEL_N(chip_sel_n), .SERIAL_IN(serial_in));
    task automatic wclk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #40000;
        mismatches++;
        complete_run();
    end
    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        touch_sense = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        wclk(1);
        chk("ctl_word", 8'h02, ctl_word);
        chk("report_en", 8'h01, report_en);
        chk("alert_o", 8'h01, alert_o);
        chk("alert_wire", 8'h01, alert_wire);
        @(posedge clock) touch_sense <= 1'b1;
        wclk(6);
        chk("alert_wire", 8'h00, alert_wire);
        // touch held across a word: alert stays low until the fourth fall
        i_touch_host_model.select();
        i_touch_host_model.shift_zeros(2);
        for (int i = 7; i >= 0; i--) begin
            i_touch_host_model.shift_bit(i[0] ? (i != 7 && i != 5 ? 1'b1 : i == 7) : i != 0);
            if (i == 5) chk("alert_wire", 8'h00, alert_wire);
            if (i == 5) chk("report_en", 8'h00, report_en);
            if (i == 4) wclk(8);
            if (i == 4) chk("alert_wire", 8'h01, alert_wire);
        end
        i_touch_host_model.shift_zeros(10);
        wclk(8);
        chk("ctl_word", 8'hDE, ctl_word);
        chk("ref_panel", 8'h00, ref_panel);
        chk("alert_wire", 8'h00, alert_wire);
        i_touch_host_model.deselect();
        foreach (tbl[k]) begin
            i_touch_host_model.select();
            i_touch_host_model.shift_word(tbl[k]);
            i_touch_host_model.shift_zeros(tbl[k][3] ? CE8 - 6 : CE12 - 6);
            wclk(8);
            chk("ctl_word", tbl[k], ctl_word);
            chk("converting", 8'h00, converting);
            chk("report_en", tbl[k][1:0] != 2'h3, report_en);
            chk("adc_pwr", tbl[k][0], adc_pwr);
            chk("ref_pwr", tbl[k][1], ref_pwr);
            chk("alert_wire", tbl[k][1:0] == 2'h3, alert_wire);
            i_touch_host_model.deselect();
        end
        // overlapped writes at the shortest spacing keep reporting off
        i_touch_host_model.select();
        i_touch_host_model.shift_word(8'hB2);
        i_touch_host_model.shift_zeros(CE12 - 9);
        i_touch_host_model.shift_word(8'hB2);
        i_touch_host_model.shift_zeros(7);
        wclk(8);
        chk("report_en", 8'h00, report_en);
        i_touch_host_model.shift_zeros(3);
        wclk(8);
        chk("report_en", 8'h01, report_en);
        i_touch_host_model.deselect();
        // partial word then deselect, next word must frame afresh
        i_touch_host_model.select();
        i_touch_host_model.shift_zeros(1);
        i_touch_host_model.shift_word(8'hFF);
        i_touch_host_model.deselect();
        i_touch_host_model.select();
        i_touch_host_model.shift_bit(1'b1);
        i_touch_host_model.shift_bit(1'b1);
        i_touch_host_model.deselect();
        wclk(8);
        chk("ctl_word", 8'hFF, ctl_word);
        chk("converting", 8'h00, converting);
        i_touch_host_model.select();
        i_touch_host_model.shift_word(8'hD6);
        i_touch_host_model.shift_zeros(10);
        wclk(8);
        chk("ctl_word", 8'hD6, ctl_word);
        i_touch_host_model.deselect();
        // touch lifted while enabled, then a reset in mid-run
        @(posedge clock) touch_sense <= 1'b0;
        wclk(6);
        chk("alert_wire", 8'h01, alert_wire);
        chk("alert_o", 8'h01, alert_o);
        @(posedge clock) reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        wclk(1);
        chk("ctl_word", 8'h02, ctl_word);
        chk("report_en", 8'h01, report_en);
        @(posedge clock) touch_sense <= 1'b1;
        wclk(6);
        chk("alert_wire", 8'h00, alert_wire);
        chk("alert_o", 8'h00, alert_o);
        complete_run();
    end
endmodule

// [touch_ctl_pkg.sv]
package touch_ctl_pkg;

    // control word layout, start flag in the most significant bit
    typedef struct packed {
        logic       start;
        logic [2:0] channel_sel;
        logic       res_8bit;
        logic       ref_mode_sel;
        logic       ref_power_ctl;
        logic       adc_power_ctl;
    } ctl_word_t;

    localparam int WORD_BITS     = 8;
    localparam int START_POS     = 7;
    localparam int CHAN_MSB      = 6;
    localparam int CHAN_LSB      = 4;
    localparam int RES_POS       = 3;
    localparam int REF_MODE_POS  = 2;
    localparam int REF_PWR_POS   = 1;
    localparam int ADC_PWR_POS   = 0;

    // power-up defaults: reference on, converter down between conversions
    localparam ctl_word_t CTL_RESET = '{
        start:         1'b0,
        channel_sel:   3'h0,
        res_8bit:      1'b0,
        ref_mode_sel:  1'b0,
        ref_power_ctl: 1'b1,
        adc_power_ctl: 1'b0
    };

    // both power bits set keeps everything up and silences touch reporting
    localparam logic [1:0] PWR_ALWAYS_ON = 2'h3;

    // shift-clock counts measured from the start flag edge
    localparam logic [4:0] CNT_START     = 5'h01;
    localparam logic [4:0] CNT_LAST_BIT  = 5'h07;
    localparam logic [4:0] CNT_RELEASE   = 5'h04;
    localparam logic [4:0] CNT_MAX       = 5'h1F;
    localparam int         CONV_END_12   = 16;
    localparam int         CONV_END_8    = 12;

    typedef enum logic [1:0] {
        HUNT,
        RECEIVE,
        CONVERT
    } frame_state_t;

endpackage

// [touch_host_model.sv]
`timescale 1ns/1ps
module touch_host_model (
    // serial control port
    output logic SHIFT_CLOCK,
    output logic CHIP_SEL_N,
    output logic SERIAL_IN
);
    // one edge inside reset so the link side leaves reset cleanly
    initial begin
        SHIFT_CLOCK = 1'b0;
        CHIP_SEL_N  = 1'b1;
        SERIAL_IN   = 1'b1;
        #2 SHIFT_CLOCK = 1'b1;
        #3 SHIFT_CLOCK = 1'b0;
    end
    // odd offset keeps the link phase unrelated to the system clock
    task automatic select();
        #7.3 CHIP_SEL_N = 1'b0;
    endtask
    // data moves while the clock is low, device samples on the rise
    task automatic shift_bit(input logic b);
        SERIAL_IN = b;
        #15 SHIFT_CLOCK = 1'b1;
        #15 SHIFT_CLOCK = 1'b0;
    endtask
    task automatic shift_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) shift_bit(w[i]);
    endtask
    task automatic shift_zeros(input int n);
        repeat (n) shift_bit(1'b0);
    endtask
    task automatic deselect();
        #15 CHIP_SEL_N = 1'b1;
        SERIAL_IN = ~SERIAL_IN;
    endtask
endmodule
